/* posl_strap_latch.sv */
// Power-on strap latch: captures board straps on reset release and power-good rise.
// Function
// [R1] Straps are captured on system reset release or power-good rise, per strap.
// [R2] Captured options hold until their own latching input latches again.
// [R3] The self-test strap is sampled only when system reset is released.
// [R4] All other straps, socket index and debug included, are sampled on power-good rise.
// [R5] Provide captured outputs for tri-state, self-test and every boot option.
// [R6] The active-low debug strap, taken at power-good, enables cold-boot debug.
// [R7] Undriven straps float to their weak-pull defaults.
// [R8] Reset and power-good are synchronised first; straps are captured on the detected edge.
`timescale 1ns/1ps
`include "posl_defs.svh"
module posl_strap_latch
	import posl_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          sysResetL,
	input  wire logic          powerGoodIn,
	input  wire posl_straps_t  strapPins,
	input  wire posl_straps_t  strapDriven,
	output posl_options_t      powerOnOptions,
	output logic               resetCaptured,
	output logic               powerGoodCaptured,
	output logic               captureStrobe
);
	posl_straps_t strapResolved;
	posl_straps_t strapNow;
	logic [1:0]   sidebandNow;
	logic         resetLSync;
	logic         powerGoodSync;
	logic         resetLPrev;
	logic         powerGoodPrev;
	logic         resetRelease;
	logic         powerGoodRise;
	posl_options_t decodedNow;
	posl_options_t next_powerOnOptions;

	// Straps active low at the land are turned into active-high options here.
	function automatic posl_options_t decodeOptions(input posl_straps_t s);
		posl_options_t o;
		o.outTriState     = ~s.overtempAlertL;
		o.selfTestRun     = s.selfTestStrap;
		o.serviceBoot     = s.serviceBootStrap;
		o.sequenceHalt    = ~s.sequenceHaltStrapL;
		o.trustedPlatform = s.trustedPlatformStrap;
		o.firmwareAgent   = s.firmwareAgentStrap;
		o.trustedAgent    = s.trustedAgentStrap;
		o.safeBoot        = s.safeBootStrap;
		o.nodeIndex       = s.nodeIndexStrap;
		o.coldDebugEn     = ~s.debugEnStrapL;
		return o;
	endfunction

	// An undriven land floats to its pull, so the pull value stands in for it.
	assign strapResolved = (strapPins & strapDriven)
		| (posl_straps_t'(`POSL_PULL_DEFAULT) & ~strapDriven); // [R7]

	posl_sync #(
		.W    (`POSL_STRAP_W),
		.INIT (`POSL_PULL_DEFAULT)
	) u_strap_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (strapResolved),
		.q       (strapNow)
	);

	// Straps pass the same three stages as the latching inputs, so the value
	// captured on an edge is the one standing at the land when that edge came.
	posl_sync #(
		.W    (2),
		.INIT (`POSL_SIDEBAND_RESET)
	) u_sideband_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       ({sysResetL, powerGoodIn}),
		.q       (sidebandNow)
	); // [R8]

	assign resetLSync    = sidebandNow[1];
	assign powerGoodSync = sidebandNow[0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resetLPrev    <= 1'b0;
			powerGoodPrev <= 1'b0;
		end else begin
			resetLPrev    <= resetLSync;
			powerGoodPrev <= powerGoodSync;
		end
	end

	assign resetRelease  = resetLSync & ~resetLPrev; // [R8]
	assign powerGoodRise = powerGoodSync & ~powerGoodPrev; // [R8]
	assign decodedNow    = decodeOptions(strapNow);

	// Each field group changes only on its own latching edge and holds otherwise.
	always_comb begin
		next_powerOnOptions = powerOnOptions; // [R2]
		if (resetRelease) begin
			next_powerOnOptions.selfTestRun = decodedNow.selfTestRun; // [R1] [R3]
		end
		if (powerGoodRise) begin
			next_powerOnOptions.outTriState     = decodedNow.outTriState; // [R5]
			next_powerOnOptions.serviceBoot     = decodedNow.serviceBoot; // [R4]
			next_powerOnOptions.sequenceHalt    = decodedNow.sequenceHalt; // [R4]
			next_powerOnOptions.trustedPlatform = decodedNow.trustedPlatform; // [R4]
			next_powerOnOptions.firmwareAgent   = decodedNow.firmwareAgent; // [R4]
			next_powerOnOptions.trustedAgent    = decodedNow.trustedAgent; // [R4]
			next_powerOnOptions.safeBoot        = decodedNow.safeBoot; // [R4]
			next_powerOnOptions.nodeIndex       = decodedNow.nodeIndex; // [R4]
			next_powerOnOptions.coldDebugEn     = decodedNow.coldDebugEn; // [R6]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			powerOnOptions <= posl_options_t'(`POSL_OPT_RESET);
		end else begin
			powerOnOptions <= next_powerOnOptions; // [R1] [R5]
		end
	end

	// The captured flags stay up once set, so software can tell pull defaults
	// from real samples; only the block reset clears them.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resetCaptured     <= 1'b0;
			powerGoodCaptured <= 1'b0;
			captureStrobe     <= 1'b0;
		end else begin
			resetCaptured     <= resetCaptured | resetRelease;
			powerGoodCaptured <= powerGoodCaptured | powerGoodRise;
			captureStrobe     <= resetRelease | powerGoodRise;
		end
	end

	property p_self_test_capture;
		@(posedge clk_sys) disable iff (rst)
		resetRelease |=> powerOnOptions.selfTestRun == $past(strapNow.selfTestStrap);
	endproperty
	a_self_test_capture: assert property (p_self_test_capture) // [R3]
		else $error("Self-test option not taken on reset release.");

	property p_self_test_hold;
		@(posedge clk_sys) disable iff (rst)
		!resetRelease |=> $stable(powerOnOptions.selfTestRun);
	endproperty
	a_self_test_hold: assert property (p_self_test_hold) // [R2]
		else $error("Self-test option changed without reset release.");

	property p_pg_group_hold;
		@(posedge clk_sys) disable iff (rst)
		!powerGoodRise |=> $stable({powerOnOptions.outTriState, powerOnOptions.serviceBoot,
			powerOnOptions.sequenceHalt, powerOnOptions.trustedPlatform,
			powerOnOptions.firmwareAgent, powerOnOptions.trustedAgent,
			powerOnOptions.safeBoot, powerOnOptions.nodeIndex, powerOnOptions.coldDebugEn});
	endproperty
	a_pg_group_hold: assert property (p_pg_group_hold) // [R2]
		else $error("Power-good options changed without power-good rise.");

	property p_pg_capture;
		@(posedge clk_sys) disable iff (rst)
		powerGoodRise |=> powerOnOptions.nodeIndex == $past(strapNow.nodeIndexStrap)
			&& powerOnOptions.sequenceHalt == !$past(strapNow.sequenceHaltStrapL)
			&& powerOnOptions.serviceBoot == $past(strapNow.serviceBootStrap);
	endproperty
	a_pg_capture: assert property (p_pg_capture) // [R4]
		else $error("Power-good straps not captured on power-good rise.");

	property p_tristate_capture;
		@(posedge clk_sys) disable iff (rst)
		powerGoodRise |=> powerOnOptions.outTriState == !$past(strapNow.overtempAlertL);
	endproperty
	a_tristate_capture: assert property (p_tristate_capture) // [R5]
		else $error("Tri-state option not taken from the alert land.");

	property p_debug_capture;
		@(posedge clk_sys) disable iff (rst)
		powerGoodRise |=> powerOnOptions.coldDebugEn == !$past(strapNow.debugEnStrapL);
	endproperty
	a_debug_capture: assert property (p_debug_capture) // [R6]
		else $error("Cold-boot debug not taken from the active-low strap.");

	property p_pull_default;
		@(posedge clk_sys) disable iff (rst)
		strapDriven == '0 |-> strapResolved == posl_straps_t'(`POSL_PULL_DEFAULT);
	endproperty
	a_pull_default: assert property (p_pull_default) // [R7]
		else $error("Undriven straps did not take their pull defaults.");

	property p_pg_sync_delay;
		@(posedge clk_sys) disable iff (rst)
		$rose(powerGoodSync) |=> captureStrobe ##1 powerGoodCaptured;
	endproperty
	a_pg_sync_delay: assert property (p_pg_sync_delay) // [R8]
		else $error("Capture did not follow the synchronised power-good edge.");

	property p_release_edge;
		@(posedge clk_sys) disable iff (rst)
		resetRelease |-> resetLSync && !resetLPrev ##1 resetCaptured && captureStrobe;
	endproperty
	a_release_edge: assert property (p_release_edge) // [R1]
		else $error("Reset release capture not flagged one cycle later.");

	property p_pg_agents_capture;
		@(posedge clk_sys) disable iff (rst)
		powerGoodRise |=> powerOnOptions.trustedPlatform == $past(strapNow.trustedPlatformStrap)
			&& powerOnOptions.firmwareAgent == $past(strapNow.firmwareAgentStrap)
			&& powerOnOptions.trustedAgent == $past(strapNow.trustedAgentStrap)
			&& powerOnOptions.safeBoot == $past(strapNow.safeBootStrap);
	endproperty
	a_pg_agents_capture: assert property (p_pg_agents_capture) // [R4]
		else $error("Agent and safe-boot straps not captured on power-good rise.");

	// A strobe with no edge behind it would make pull defaults look like real samples.
	property p_strobe_source;
		@(posedge clk_sys) disable iff (rst)
		captureStrobe |-> $past(resetRelease) || $past(powerGoodRise);
	endproperty
	a_strobe_source: assert property (p_strobe_source) // [R8]
		else $error("Capture strobe raised without a latching edge.");

	property p_flags_sticky;
		@(posedge clk_sys) disable iff (rst)
		resetCaptured || powerGoodCaptured |=> resetCaptured >= $past(resetCaptured)
			&& powerGoodCaptured >= $past(powerGoodCaptured);
	endproperty
	a_flags_sticky: assert property (p_flags_sticky) // [R1]
		else $error("A captured flag dropped without block reset.");
endmodule // posl_strap_latch

/* posl_defs.svh */
// Constants for the power-on strap latch: widths, pull defaults and reset values.
`ifndef POSL_DEFS_SVH
`define POSL_DEFS_SVH

`define POSL_STRAP_W 11
`define POSL_OPT_W 11
// Level each strap floats to through its on-die weak pull when nothing drives it.
`define POSL_PULL_DEFAULT 11'h6c1
// Options shown before any capture: the decoded pull defaults.
`define POSL_OPT_RESET 11'h240
// Reset value of the synchronised reset and power-good pins: both low, so reset reads asserted and power-good reads down.
`define POSL_SIDEBAND_RESET 2'h0
`define POSL_SYNC_AGREE_STAGES 3

`endif

/* posl_pkg.sv */
// Types shared by the power-on strap latch.
package posl_pkg;

	typedef struct packed {
		logic       overtempAlertL;
		logic       selfTestStrap;
		logic       serviceBootStrap;
		logic       sequenceHaltStrapL;
		logic       trustedPlatformStrap;
		logic       firmwareAgentStrap;
		logic       trustedAgentStrap;
		logic       safeBootStrap;
		logic [1:0] nodeIndexStrap;
		logic       debugEnStrapL;
	} posl_straps_t;

	typedef struct packed {
		logic       outTriState;
		logic       selfTestRun;
		logic       serviceBoot;
		logic       sequenceHalt;
		logic       trustedPlatform;
		logic       firmwareAgent;
		logic       trustedAgent;
		logic       safeBoot;
		logic [1:0] nodeIndex;
		logic       coldDebugEn;
	} posl_options_t;

endpackage

/* posl_sync.sv */
// Three-stage synchroniser whose output follows only when stages two and three agree.
`timescale 1ns/1ps
module posl_sync #(
	parameter int          W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_q;

	// Stage one feeds stage two only; the agreement test looks at two and three.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			q      <= INIT;
		end else begin
			stage1 <= d;
			stage2 <= stage1;
			stage3 <= stage2;
			q      <= next_q;
		end
	end

	// A bit moves only while stages two and three agree, so a one-cycle glitch never reaches q.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_agree
			assign next_q[i] = (stage2[i] == stage3[i]) ? stage3[i] : q[i];
		end
	endgenerate
endmodule // posl_sync

/* posl_board_model.sv */
// Board model: drives the reset, power-good and strap lands of the latch.
`timescale 1ns/1ps
`include "posl_defs.svh"
module posl_board_model
	import posl_pkg::*;
(
	input  wire logic   clk_sys,
	output logic        sysResetL,
	output logic        powerGoodIn,
	output posl_straps_t strapPins,
	output posl_straps_t strapDriven
);
	initial begin
		sysResetL = 1'b0;
		powerGoodIn = 1'b0;
		strapPins = ~`POSL_PULL_DEFAULT;
		strapDriven = '0;
	end

	// A floating land shows the opposite of its pull, so only the on-die pull can give the default.
	task automatic drive(input logic rl, input logic pg, input posl_straps_t v,
		input posl_straps_t m);
		@(negedge clk_sys);
		sysResetL <= rl;
		powerGoodIn <= pg;
		strapPins <= (v & m) | (~`POSL_PULL_DEFAULT & ~m);
		strapDriven <= m;
	endtask
endmodule // posl_board_model

/* tb_top.sv */
// Self-checking bench for the power-on strap latch.
`timescale 1ns/1ps
`include "posl_defs.svh"
module tb_top
	import posl_pkg::*;
;
	logic          clk_sys;
	logic          rst;
	logic          sysResetL;
	logic          powerGoodIn;
	logic          resetCaptured;
	logic          powerGoodCaptured;
	logic          captureStrobe;
	posl_straps_t  strapPins;
	posl_straps_t  strapDriven;
	posl_options_t powerOnOptions;
	int            failures;
	int            n_compared;
	localparam posl_straps_t ALL = 11'h7ff;
	localparam posl_straps_t SA = 11'h13e;

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	posl_board_model u_board (.clk_sys(clk_sys), .sysResetL(sysResetL),
		.powerGoodIn(powerGoodIn), .strapPins(strapPins), .strapDriven(strapDriven));
	posl_strap_latch u_dut (.clk_sys(clk_sys), .rst(rst), .sysResetL(sysResetL),
		.powerGoodIn(powerGoodIn), .strapPins(strapPins), .strapDriven(strapDriven),
		.powerOnOptions(powerOnOptions), .resetCaptured(resetCaptured),
		.powerGoodCaptured(powerGoodCaptured), .captureStrobe(captureStrobe));

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_opt(input string what, input posl_options_t exp, input posl_options_t got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Called right after a latching pin edge; counts rising edges up to the capture pulse.
	task automatic expect_capture(input posl_options_t exp);
		logic [7:0] lat;
		lat = 8'h0;
		for (int i = 0; i < 20 && captureStrobe !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
			lat = lat + 8'h1;
		end
		if (captureStrobe !== 1'b1) begin
			chk_val("capture strobe", 8'h1, {7'h0, captureStrobe});
			wrap_up();
		end
		chk_val("capture latency", 8'h5, lat);
		chk_opt("options", exp, powerOnOptions);
		@(posedge clk_sys);
		#1;
		chk_val("strobe width", 8'h0, {7'h0, captureStrobe});
	endtask

	task automatic t_cold_boot();
		u_board.drive(1'b0, 1'b0, SA, ALL);
		repeat (8) @(negedge clk_sys);
		u_board.drive(1'b1, 1'b0, SA, ALL);
		expect_capture(11'h040);
		chk_val("flags", 8'h2, {6'h0, resetCaptured, powerGoodCaptured});
		u_board.drive(1'b1, 1'b1, SA, ALL);
		expect_capture(11'h5bf);
		chk_val("flags", 8'h3, {6'h0, resetCaptured, powerGoodCaptured});
	endtask

	// Floating lands with both latching edges together bring back every pull default.
	task automatic t_float();
		u_board.drive(1'b0, 1'b0, SA, '0);
		repeat (8) @(negedge clk_sys);
		u_board.drive(1'b1, 1'b1, SA, '0);
		expect_capture(`POSL_OPT_RESET);
	endtask

	task automatic t_hold();
		u_board.drive(1'b1, 1'b1, SA, ALL);
		repeat (12) @(negedge clk_sys);
		chk_opt("no edge", `POSL_OPT_RESET, powerOnOptions);
		u_board.drive(1'b0, 1'b0, SA, ALL);
		repeat (12) @(negedge clk_sys);
		chk_opt("falling edges", `POSL_OPT_RESET, powerOnOptions);
		u_board.drive(1'b0, 1'b1, SA, ALL);
		expect_capture(11'h7bf);
		u_board.drive(1'b1, 1'b1, SA, ALL);
		expect_capture(11'h5bf);
	endtask

	// A mid-run block reset with both latching pins high counts as a fresh pair of edges.
	task automatic t_rerun();
		@(negedge clk_sys);
		rst <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk_opt("options in reset", `POSL_OPT_RESET, powerOnOptions);
		chk_val("flags in reset", 8'h0, {6'h0, resetCaptured, powerGoodCaptured});
		rst <= 1'b0;
		expect_capture(11'h5bf);
		chk_val("flags", 8'h3, {6'h0, resetCaptured, powerGoodCaptured});
	endtask

	initial begin
		failures = 0;
		n_compared = 0;
		rst = 1'b1;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk_opt("reset options", `POSL_OPT_RESET, powerOnOptions);
		chk_val("reset flags", 8'h0, {6'h0, resetCaptured, powerGoodCaptured});
		t_cold_boot();
		t_float();
		t_hold();
		t_rerun();
		wrap_up();
	end
endmodule // tb_top
